// ==== hdl/compare_branch_load_exec.sv ====
// Executor for compares, skips, flag branches and indirect loads.
// Assumes combinational register file, I/O and data memory read ports.
`timescale 1ns/1ps
`default_nettype none
module compare_branch_load_exec
    import exec_pkg::*;
(
    input wire logic clk_sys_in, // Core clock
    input wire logic rst_in, // Sync reset
    input wire logic instr_valid_in, // Operation offered
    input wire op_t op_in, // Operation
    input wire logic [REG_AW-1:0] dst_sel_in, // Destination register
    input wire logic [REG_AW-1:0] src_sel_in, // Source register or pointer
    input wire logic [DATA_W-1:0] imm_in, // K, I/O addr, q or offset
    input wire logic [2:0] bit_sel_in, // Bit or flag index
    input wire logic next_long_in, // Following instruction is two words
    input wire logic [PC_W-1:0] pc_in, // Address of this operation
    input wire logic [DATA_W-1:0] status_flags_in, // Current status flags
    input wire logic [DATA_W-1:0] rd_val_in, // Destination register value
    input wire logic [DATA_W-1:0] rr_val_in, // Source register value
    input wire logic [DATA_W-1:0] io_val_in, // Addressed I/O value
    input wire logic [PTR_W-1:0] ptr_x_in, // X pointer
    input wire logic [PTR_W-1:0] ptr_y_in, // Y pointer
    input wire logic [PTR_W-1:0] ptr_z_in, // Z pointer
    input wire logic [DATA_W-1:0] mem_rdata_in, // Data memory read data
    output logic ready_out, // Can take an operation
    output logic [REG_AW-1:0] rd_addr_out, // Register read port A
    output logic [REG_AW-1:0] rr_addr_out, // Register read port B
    output logic [IO_AW-1:0] io_addr_out, // I/O read address
    output logic done_out, // Operation complete
    output logic [PC_W-1:0] pc_next_out, // Next program counter
    output logic status_we_out, // Status write strobe
    output logic [DATA_W-1:0] status_flags_out, // New status flags
    output logic reg_we_out, // Register write strobe
    output logic [REG_AW-1:0] reg_waddr_out, // Register write address
    output logic [DATA_W-1:0] reg_wdata_out, // Register write data
    output logic ptr_we_out, // Pointer write strobe
    output logic [1:0] ptr_sel_out, // Pointer written
    output logic [PTR_W-1:0] ptr_val_out, // New pointer value
    output logic mem_rd_out, // Data memory read
    output logic [PTR_W-1:0] mem_addr_out // Data memory address
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [PTR_W-1:0] pick_ptr(logic [1:0] sel, logic [PTR_W-1:0] x,
                                                 logic [PTR_W-1:0] y, logic [PTR_W-1:0] z);
        case (sel)
            PTR_X: pick_ptr = x;
            PTR_Y: pick_ptr = y;
            default: pick_ptr = z;
        endcase
    endfunction

    function automatic logic [DATA_W-1:0] put_flag(logic [DATA_W-1:0] f, logic [2:0] pos, logic v);
        logic [DATA_W-1:0] r;
        r = f;
        r[pos] = v;
        put_flag = r;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    exec_state_t state_q;
    logic [1:0] wait_q;
    logic done_q;
    logic [PC_W-1:0] pc_next_q;
    logic [DATA_W-1:0] flags_q;
    logic flags_upd_q;
    logic reg_upd_q;
    logic [REG_AW-1:0] waddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic ptr_upd_q;
    logic [1:0] ptr_sel_q;
    logic [PTR_W-1:0] ptr_val_q;
    logic [PTR_W-1:0] mem_addr_q;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic accept;
    logic is_cmp;
    logic is_load;
    logic ld_inc;
    logic ld_dec;
    logic ld_ofs;
    assign ready_out = (state_q == st_idle);
    assign accept = instr_valid_in & ready_out;
    assign is_cmp = (op_in == op_compare_registers) | (op_in == op_compare_with_carry)
                  | (op_in == op_compare_immediate);
    assign ld_inc = (op_in == op_load_indirect_inc);
    assign ld_dec = (op_in == op_load_indirect_dec);
    assign ld_ofs = (op_in == op_load_indirect_offset);
    assign is_load = (op_in == op_load_indirect) | ld_inc | ld_dec | ld_ofs;
    assign rd_addr_out = dst_sel_in;
    assign rr_addr_out = src_sel_in;
    assign io_addr_out = imm_in[IO_AW-1:0];

    // ----------------------------------------
    // Compare arithmetic
    // ----------------------------------------
    logic [DATA_W-1:0] cmp_rhs;
    logic cmp_cin;
    logic [DATA_W:0] diff9;
    logic [NIB_W:0] half5;
    logic cmp_v;
    logic [DATA_W-1:0] cmp_flags;
    assign cmp_rhs = (op_in == op_compare_immediate) ? imm_in : rr_val_in;
    assign cmp_cin = (op_in == op_compare_with_carry) & status_flags_in[FLAG_C];
    assign diff9 = {1'b0, rd_val_in} - {1'b0, cmp_rhs} - {{DATA_W{1'b0}}, cmp_cin};
    assign half5 = {1'b0, rd_val_in[NIB_W-1:0]} - {1'b0, cmp_rhs[NIB_W-1:0]}
                 - {{NIB_W{1'b0}}, cmp_cin};
    assign cmp_v = (rd_val_in[DATA_W-1] & ~cmp_rhs[DATA_W-1] & ~diff9[DATA_W-1])
                 | (~rd_val_in[DATA_W-1] & cmp_rhs[DATA_W-1] & diff9[DATA_W-1]);
    assign cmp_flags = put_flag(put_flag(put_flag(put_flag(put_flag(status_flags_in,
                           FLAG_Z, diff9[DATA_W-1:0] == BYTE_ZERO),
                           FLAG_N, diff9[DATA_W-1]),
                           FLAG_V, cmp_v),
                           FLAG_C, diff9[DATA_W]),
                           FLAG_H, half5[NIB_W]);

    // ----------------------------------------
    // Conditions and next program counter
    // ----------------------------------------
    cond_if cnd ();
    assign cnd.op = op_in;
    assign cnd.flags = status_flags_in;
    assign cnd.bit_sel = bit_sel_in;
    assign cnd.reg_bit = rr_val_in[bit_sel_in];
    assign cnd.io_bit = io_val_in[bit_sel_in];
    assign cnd.regs_equal = (rd_val_in == rr_val_in);

    cond_eval u_cond (
        .cnd(cnd.evaluator)
    );

    logic skip_go;
    logic branch_go;
    logic [PC_W-1:0] rel_ofs;
    logic [PC_W-1:0] skip_dist;
    logic [PC_W-1:0] pc_target;
    logic [1:0] cycles;
    assign skip_go = cnd.is_skip & cnd.taken;
    assign branch_go = cnd.is_branch & cnd.taken;
    assign rel_ofs = {{(PC_W-OFS_W){imm_in[OFS_W-1]}}, imm_in[OFS_W-1:0]};
    assign skip_dist = next_long_in ? SKIP_TWO_WORD : SKIP_ONE_WORD;
    assign pc_target = skip_go ? pc_in + skip_dist
                     : branch_go ? pc_in + rel_ofs + PC_STEP
                     : pc_in + PC_STEP;
    assign cycles = skip_go ? (next_long_in ? CYC_THREE : CYC_TWO)
                  : (branch_go | is_load) ? CYC_TWO
                  : CYC_ONE;

    // ----------------------------------------
    // Pointer arithmetic
    // ----------------------------------------
    logic [PTR_W-1:0] ptr_base;
    logic [PTR_W-1:0] ld_addr;
    logic [PTR_W-1:0] ptr_new;
    assign ptr_base = pick_ptr(src_sel_in[1:0], ptr_x_in, ptr_y_in, ptr_z_in);
    assign ld_addr = ld_dec ? ptr_base - PTR_STEP
                   : ld_ofs ? ptr_base + {{(PTR_W-DATA_W){1'b0}}, imm_in}
                   : ptr_base;
    assign ptr_new = ld_inc ? ptr_base + PTR_STEP : ptr_base - PTR_STEP;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_q <= st_idle;
            wait_q <= 2'h0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                st_idle: begin
                    if (accept && is_load) begin
                        state_q <= st_load;
                    end else if (accept && cycles != CYC_ONE) begin
                        state_q <= st_wait;
                        wait_q <= cycles - CYC_ONE;
                    end else if (accept) begin
                        done_q <= 1'b1;
                    end
                end
                st_wait: begin
                    wait_q <= wait_q - CYC_ONE;
                    if (wait_q == CYC_ONE) begin
                        done_q <= 1'b1;
                        state_q <= st_idle;
                    end
                end
                st_load: begin
                    done_q <= 1'b1;
                    state_q <= st_idle;
                end
                default: state_q <= st_idle;
            endcase
        end
    end

    // ----------------------------------------
    // Result capture
    // ----------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            pc_next_q <= {PC_W{1'b0}};
            flags_q <= BYTE_ZERO;
            flags_upd_q <= 1'b0;
            reg_upd_q <= 1'b0;
            waddr_q <= {REG_AW{1'b0}};
            ptr_upd_q <= 1'b0;
            ptr_sel_q <= PTR_X;
            ptr_val_q <= {PTR_W{1'b0}};
            mem_addr_q <= {PTR_W{1'b0}};
        end else if (accept) begin
            pc_next_q <= pc_target;
            flags_q <= is_cmp ? cmp_flags : status_flags_in;
            flags_upd_q <= is_cmp;
            reg_upd_q <= is_load;
            waddr_q <= dst_sel_in;
            ptr_upd_q <= ld_inc | ld_dec;
            ptr_sel_q <= src_sel_in[1:0];
            ptr_val_q <= ptr_new;
            mem_addr_q <= ld_addr;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            wdata_q <= BYTE_ZERO;
        end else if (state_q == st_load) begin
            wdata_q <= mem_rdata_in;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign done_out = done_q;
    assign pc_next_out = pc_next_q;
    assign status_we_out = done_q & flags_upd_q;
    assign status_flags_out = flags_q;
    assign reg_we_out = done_q & reg_upd_q;
    assign reg_waddr_out = waddr_q;
    assign reg_wdata_out = wdata_q;
    assign ptr_we_out = done_q & ptr_upd_q;
    assign ptr_sel_out = ptr_sel_q;
    assign ptr_val_out = ptr_val_q;
    assign mem_rd_out = (state_q == st_load);
    assign mem_addr_out = mem_addr_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    property p_cmp_one_cycle;
        accept && is_cmp |=> done_out && status_we_out && !reg_we_out && ready_out;
    endproperty
    a_cmp_one_cycle: assert property (p_cmp_one_cycle) else $error("compare not one cycle");

    property p_cmp_equal;
        accept && is_cmp && !cmp_cin && rd_val_in == cmp_rhs
            |=> status_flags_out[FLAG_Z] && !status_flags_out[FLAG_C] && !status_flags_out[FLAG_N];
    endproperty
    a_cmp_equal: assert property (p_cmp_equal) else $error("equal compare flags wrong");

    property p_skip_reg_short;
        accept && op_in == op_skip_reg_bit_set && rr_val_in[bit_sel_in] && !next_long_in
            |=> !done_out ##1 done_out && pc_next_out == $past(pc_in, 2) + SKIP_ONE_WORD;
    endproperty
    a_skip_reg_short: assert property (p_skip_reg_short) else $error("register skip wrong");

    property p_skip_io_long;
        accept && op_in == op_skip_io_bit_clear && !io_val_in[bit_sel_in] && next_long_in
            |=> !done_out [*2] ##1 done_out && !status_we_out;
    endproperty
    a_skip_io_long: assert property (p_skip_io_long) else $error("io skip not three cycles");

    property p_branch_untaken;
        accept && cnd.is_branch && !cnd.taken |=> done_out && pc_next_out == $past(pc_in) + PC_STEP;
    endproperty
    a_branch_untaken: assert property (p_branch_untaken) else $error("untaken branch wrong");

    property p_branch_equal;
        accept && op_in == op_branch_equal && status_flags_in[FLAG_Z]
            |=> !done_out ##1 done_out && pc_next_out == $past(pc_in, 2) + $past(rel_ofs, 2) + PC_STEP;
    endproperty
    a_branch_equal: assert property (p_branch_equal) else $error("equal branch target wrong");

    property p_signed_lt;
        accept && op_in == op_branch_signed_lt && (status_flags_in[FLAG_N] ^ status_flags_in[FLAG_V])
            |=> !ready_out ##1 ready_out;
    endproperty
    a_signed_lt: assert property (p_signed_lt) else $error("signed less branch not taken");

    property p_load_inc;
        accept && ld_inc |=> mem_rd_out && mem_addr_out == $past(ptr_base)
            ##1 done_out && reg_we_out && ptr_we_out && ptr_val_out == $past(ptr_base, 2) + PTR_STEP;
    endproperty
    a_load_inc: assert property (p_load_inc) else $error("post-increment load wrong");

    property p_load_dec;
        accept && ld_dec |=> mem_addr_out == $past(ptr_base) - PTR_STEP ##1 ptr_val_out == mem_addr_out;
    endproperty
    a_load_dec: assert property (p_load_dec) else $error("pre-decrement load wrong");

    property p_load_ofs;
        accept && ld_ofs |=> mem_rd_out && mem_addr_out == $past(ptr_base) + $past(imm_in)
            ##1 done_out && !ptr_we_out && !status_we_out;
    endproperty
    a_load_ofs: assert property (p_load_ofs) else $error("displacement load wrong");

    property p_skip_equal;
        accept && op_in == op_compare_skip_equal && rd_val_in == rr_val_in && !next_long_in
            |=> ##1 done_out && pc_next_out == $past(pc_in, 2) + SKIP_ONE_WORD;
    endproperty
    a_skip_equal: assert property (p_skip_equal) else $error("compare skip wrong");

endmodule // compare_branch_load_exec
`default_nettype wire

// ==== hdl/cond_eval.sv ====
// Skip and branch condition evaluator.
// Assumes the executor supplies the tested bits for the current operation.
`timescale 1ns/1ps
`default_nettype none
module cond_eval
    import exec_pkg::*;
(
    cond_if.evaluator cnd // Condition bundle
);

    // ----------------------------------------
    // Classify: {is_skip, is_branch, taken}
    // ----------------------------------------
    function automatic logic [2:0] classify(op_t op, logic [DATA_W-1:0] f, logic [2:0] s,
                                            logic rb, logic ib, logic eq);
        case (op)
            op_compare_skip_equal: classify = {2'b10, eq};
            op_skip_reg_bit_clear: classify = {2'b10, ~rb};
            op_skip_reg_bit_set: classify = {2'b10, rb};
            op_skip_io_bit_clear: classify = {2'b10, ~ib};
            op_skip_io_bit_set: classify = {2'b10, ib};
            op_branch_flag_set: classify = {2'b01, f[s]};
            op_branch_flag_clear: classify = {2'b01, ~f[s]};
            op_branch_equal: classify = {2'b01, f[FLAG_Z]};
            op_branch_not_equal: classify = {2'b01, ~f[FLAG_Z]};
            op_branch_carry_set: classify = {2'b01, f[FLAG_C]};
            op_branch_lower: classify = {2'b01, f[FLAG_C]};
            op_branch_carry_clear: classify = {2'b01, ~f[FLAG_C]};
            op_branch_same_or_higher: classify = {2'b01, ~f[FLAG_C]};
            op_branch_minus: classify = {2'b01, f[FLAG_N]};
            op_branch_plus: classify = {2'b01, ~f[FLAG_N]};
            op_branch_signed_ge: classify = {2'b01, ~(f[FLAG_N] ^ f[FLAG_V])};
            op_branch_signed_lt: classify = {2'b01, f[FLAG_N] ^ f[FLAG_V]};
            op_branch_half_carry_set: classify = {2'b01, f[FLAG_H]};
            op_branch_half_carry_clear: classify = {2'b01, ~f[FLAG_H]};
            op_branch_transfer_bit_set: classify = {2'b01, f[FLAG_T]};
            op_branch_transfer_bit_clear: classify = {2'b01, ~f[FLAG_T]};
            op_branch_overflow_set: classify = {2'b01, f[FLAG_V]};
            op_branch_overflow_clear: classify = {2'b01, ~f[FLAG_V]};
            op_branch_irq_enabled: classify = {2'b01, f[FLAG_I]};
            op_branch_irq_disabled: classify = {2'b01, ~f[FLAG_I]};
            default: classify = 3'h0;
        endcase
    endfunction

    assign {cnd.is_skip, cnd.is_branch, cnd.taken} =
        classify(cnd.op, cnd.flags, cnd.bit_sel, cnd.reg_bit, cnd.io_bit, cnd.regs_equal);

endmodule // cond_eval
`default_nettype wire

// ==== pkg/cond_if.sv ====
// Condition evaluation bundle between the executor and its evaluator.
// Assumes all members are combinational within one core clock cycle.
`timescale 1ns/1ps
`default_nettype none
interface cond_if;
    import exec_pkg::*;
    op_t op;
    logic [DATA_W-1:0] flags;
    logic [2:0] bit_sel;
    logic reg_bit;
    logic io_bit;
    logic regs_equal;
    logic is_skip;
    logic is_branch;
    logic taken;
    modport evaluator(input op, flags, bit_sel, reg_bit, io_bit, regs_equal,
                      output is_skip, is_branch, taken);
    modport user(output op, flags, bit_sel, reg_bit, io_bit, regs_equal,
                 input is_skip, is_branch, taken);
endinterface
`default_nettype wire

// ==== pkg/exec_pkg.sv ====
// Shared constants and types of the compare, branch and indirect-load slice.
// Assumes one core clock and a register file with combinational read ports.
package exec_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int DATA_W = 8;
    localparam int PC_W = 12;
    localparam int PTR_W = 16;
    localparam int REG_AW = 5;
    localparam int IO_AW = 5;
    localparam int NIB_W = 4;
    localparam int OFS_W = 7;

    // ----------------------------------------
    // Status flag positions
    // ----------------------------------------
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    // ----------------------------------------
    // Program counter and pointer steps, cycle counts, pointer selects, zero byte
    // ----------------------------------------
    localparam logic [PC_W-1:0] PC_STEP = 12'h001;
    localparam logic [PC_W-1:0] SKIP_ONE_WORD = 12'h002;
    localparam logic [PC_W-1:0] SKIP_TWO_WORD = 12'h003;
    localparam logic [PTR_W-1:0] PTR_STEP = 16'h0001;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    localparam logic [1:0] PTR_X = 2'h0;
    localparam logic [1:0] PTR_Y = 2'h1;
    localparam logic [1:0] PTR_Z = 2'h2;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

    // ----------------------------------------
    // Operations
    // ----------------------------------------
    typedef enum logic [5:0] {
        op_nop,
        op_compare_registers,
        op_compare_with_carry,
        op_compare_immediate,
        op_compare_skip_equal,
        op_skip_reg_bit_clear,
        op_skip_reg_bit_set,
        op_skip_io_bit_clear,
        op_skip_io_bit_set,
        op_branch_flag_set,
        op_branch_flag_clear,
        op_branch_equal,
        op_branch_not_equal,
        op_branch_carry_set,
        op_branch_carry_clear,
        op_branch_same_or_higher,
        op_branch_lower,
        op_branch_minus,
        op_branch_plus,
        op_branch_signed_ge,
        op_branch_signed_lt,
        op_branch_half_carry_set,
        op_branch_half_carry_clear,
        op_branch_transfer_bit_set,
        op_branch_transfer_bit_clear,
        op_branch_overflow_set,
        op_branch_overflow_clear,
        op_branch_irq_enabled,
        op_branch_irq_disabled,
        op_load_indirect,
        op_load_indirect_inc,
        op_load_indirect_dec,
        op_load_indirect_offset
    } op_t;

    typedef enum logic [1:0] {
        st_idle,
        st_wait,
        st_load
    } exec_state_t;

endpackage

// ==== verification/tb.sv ====
// Self-checking bench for the compare, branch and indirect-load executor.
// Assumes done pulses 1, 2 or 3 cycles after accept and back-to-back issue.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import exec_pkg::*;
    logic clk_sys_in = 1'b0, rst_in = 1'b1, instr_valid_in = 1'b0, next_long_in = 1'b0;
    op_t op_in = op_nop;
    logic [4:0] dst_sel_in = '0, src_sel_in = '0, rd_addr_out, rr_addr_out, io_addr_out, reg_waddr_out;
    logic [1:0] ptr_sel_out;
    logic [7:0] imm_in = '0, status_flags_in = '0, rd_val_in = '0, rr_val_in = '0, io_val_in = '0, mem_rdata_in = '0;
    logic [2:0] bit_sel_in = '0;
    logic [11:0] pc_in = '0, pc_next_out;
    logic [15:0] ptr_x_in = '0, ptr_y_in = '0, ptr_z_in = '0, ptr_val_out, mem_addr_out;
    logic done_out, status_we_out, reg_we_out, ptr_we_out, ready_out, mem_rd_out;
    logic [7:0] status_flags_out, reg_wdata_out;
    logic [31:0] x = 32'h0000_75ce;
    int errors = 0, num_checks = 0, cyc = 0;
    compare_branch_load_exec DUT (.clk_sys_in, .rst_in, .instr_valid_in, .op_in, .dst_sel_in, .src_sel_in,
        .imm_in, .bit_sel_in, .next_long_in, .pc_in, .status_flags_in, .rd_val_in, .rr_val_in, .io_val_in,
        .ptr_x_in, .ptr_y_in, .ptr_z_in, .mem_rdata_in, .ready_out, .rd_addr_out, .rr_addr_out,
        .io_addr_out, .done_out, .pc_next_out, .status_we_out, .status_flags_out, .reg_we_out,
        .reg_waddr_out, .reg_wdata_out, .ptr_we_out, .ptr_sel_out, .ptr_val_out, .mem_rd_out,
        .mem_addr_out);
    initial forever #25 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            finish_test();
        end
    end
    function automatic logic [31:0] rnd();
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // ----------------------------------------
    // Expected behaviour
    // ----------------------------------------
    function automatic bit tk(op_t o, logic [7:0] f, rd, rr, io, logic [2:0] b);
        case (o)
            op_compare_skip_equal: return rd == rr;
            op_skip_reg_bit_clear: return !rr[b];
            op_skip_reg_bit_set: return rr[b];
            op_skip_io_bit_clear: return !io[b];
            op_skip_io_bit_set: return io[b];
            op_branch_flag_set: return f[b];
            op_branch_flag_clear: return !f[b];
            op_branch_equal: return f[FLAG_Z];
            op_branch_not_equal: return !f[FLAG_Z];
            op_branch_carry_set, op_branch_lower: return f[FLAG_C];
            op_branch_carry_clear, op_branch_same_or_higher: return !f[FLAG_C];
            op_branch_minus: return f[FLAG_N];
            op_branch_plus: return !f[FLAG_N];
            op_branch_signed_ge: return !(f[FLAG_N] ^ f[FLAG_V]);
            op_branch_signed_lt: return f[FLAG_N] ^ f[FLAG_V];
            op_branch_half_carry_set: return f[FLAG_H];
            op_branch_half_carry_clear: return !f[FLAG_H];
            op_branch_transfer_bit_set: return f[FLAG_T];
            op_branch_transfer_bit_clear: return !f[FLAG_T];
            op_branch_overflow_set: return f[FLAG_V];
            op_branch_overflow_clear: return !f[FLAG_V];
            op_branch_irq_enabled: return f[FLAG_I];
            op_branch_irq_disabled: return !f[FLAG_I];
            default: return 1'b0;
        endcase
    endfunction
    function automatic logic [7:0] cf(logic [7:0] f, a, b, logic ci);
        logic [8:0] d;
        logic [4:0] h;
        d = {1'b0, a} - {1'b0, b} - ci;
        h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - ci;
        cf = f;
        cf[FLAG_C] = d[8];
        cf[FLAG_Z] = d[7:0] == 8'h00;
        cf[FLAG_N] = d[7];
        cf[FLAG_V] = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
        cf[FLAG_H] = h[4];
    endfunction
    task automatic chk(string nm, logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ----------------------------------------
    // One operation, issued back to back
    // ----------------------------------------
    task automatic run();
        int n, e;
        logic t, sk, cm, ld, inc, dec;
        logic [15:0] p, a;
        logic [11:0] pc;
        t = tk(op_in, status_flags_in, rd_val_in, rr_val_in, io_val_in, bit_sel_in);
        sk = op_in >= op_compare_skip_equal && op_in <= op_skip_io_bit_set;
        cm = op_in >= op_compare_registers && op_in <= op_compare_immediate;
        ld = op_in >= op_load_indirect;
        inc = op_in == op_load_indirect_inc;
        dec = op_in == op_load_indirect_dec;
        p = src_sel_in[1:0] == PTR_X ? ptr_x_in : src_sel_in[1:0] == PTR_Y ? ptr_y_in : ptr_z_in;
        a = dec ? p - 16'h0001 : op_in == op_load_indirect_offset ? p + {8'h00, imm_in} : p;
        pc = !t ? pc_in + 12'h001 : sk ? pc_in + (next_long_in ? 12'h003 : 12'h002)
            : pc_in + {{5{imm_in[6]}}, imm_in[6:0]} + 12'h001;
        e = ld ? 2 : !t ? 1 : sk && next_long_in ? 3 : 2;
        #1;
        chk("ready_idle", ready_out, 1'b1);
        chk("rd_addr", rd_addr_out, dst_sel_in);
        chk("rr_addr", rr_addr_out, src_sel_in);
        chk("io_addr", io_addr_out, imm_in[4:0]);
        @(posedge clk_sys_in);
        #1;
        chk("ready_busy", ready_out, e == 1);
        chk("mem_rd", mem_rd_out, ld);
        n = 1;
        while (done_out !== 1'b1 && n < 4) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        chk("cycles", n, e);
        chk("pc_next", pc_next_out, pc);
        chk("flags", status_flags_out, cm ? cf(status_flags_in, rd_val_in, op_in == op_compare_immediate
            ? imm_in : rr_val_in, op_in == op_compare_with_carry & status_flags_in[FLAG_C]) : status_flags_in);
        chk("status_we", status_we_out, cm);
        if (ld) chk("reg_waddr", reg_waddr_out, dst_sel_in);
        if (inc | dec) chk("ptr_sel", ptr_sel_out, src_sel_in[1:0]);
        chk("reg_we", reg_we_out, ld);
        chk("ptr_we", ptr_we_out, inc | dec);
        if (ld) chk("mem_addr", mem_addr_out, a);
        if (ld) chk("reg_wdata", reg_wdata_out, mem_rdata_in);
        if (inc | dec) chk("ptr_val", ptr_val_out, inc ? p + 16'h0001 : a);
    endtask
    initial begin
        repeat (16) @(posedge clk_sys_in);
        #1;
        chk("rst_done", done_out, 1'b0);
        chk("rst_ready", ready_out, 1'b1);
        chk("rst_pc", pc_next_out, 12'h000);
        rst_in = 1'b0;
        @(posedge clk_sys_in);
        #1 instr_valid_in = 1'b1;
        for (int k = 0; k < 700; k++) begin
            op_in = op_t'(k < 66 ? k % 33 : rnd() % 33);
            {dst_sel_in, src_sel_in, imm_in, bit_sel_in, next_long_in, pc_in} = rnd();
            status_flags_in = k < 33 ? 8'hff : k < 66 ? 8'h00 : rnd();
            {rd_val_in, rr_val_in, io_val_in, mem_rdata_in} = rnd();
            if (rnd() % 4 == 0) rr_val_in = rd_val_in;
            {ptr_x_in, ptr_y_in} = rnd();
            ptr_z_in = k % 5 == 0 ? 16'h0000 : rnd();
            run();
        end
        finish_test();
    end
endmodule // tb
`default_nettype wire
